//--- logic/isra_pkg.sv
package isra_pkg;

   // frame layout
   localparam int          FRAME_BITS   = 16;
   localparam int          BIT_WRITE    = 15;
   localparam int          BIT_ZERO     = 14;
   localparam int          ADDR_MSB     = 13;
   localparam int          ADDR_LSB     = 8;
   localparam int          ADDR_W       = 6;
   localparam int          BYTE_W       = 8;

   // output data register layout
   localparam int          BIT_NEW      = 15;
   localparam int          BIT_ERR      = 14;
   localparam int          DATA_W       = 14;
   localparam logic [13:0] MASK_14      = 14'h3fff;
   localparam logic [13:0] MASK_12      = 14'h0fff;

   // byte address map
   localparam logic [5:0]  ADDR_SUPPLY  = 6'h02;
   localparam logic [5:0]  ADDR_RATE_X  = 6'h04;
   localparam logic [5:0]  ADDR_RATE_Y  = 6'h06;
   localparam logic [5:0]  ADDR_RATE_Z  = 6'h08;
   localparam logic [5:0]  ADDR_ACCEL_X = 6'h0a;
   localparam logic [5:0]  ADDR_ACCEL_Y = 6'h0c;
   localparam logic [5:0]  ADDR_ACCEL_Z = 6'h0e;
   localparam logic [5:0]  ADDR_TEMP_X  = 6'h10;
   localparam logic [5:0]  ADDR_TEMP_Y  = 6'h12;
   localparam logic [5:0]  ADDR_TEMP_Z  = 6'h14;
   localparam logic [5:0]  ADDR_AUX     = 6'h16;
   localparam logic [5:0]  ADDR_CFG_LO  = 6'h1a;
   localparam logic [5:0]  ADDR_CFG_HI  = 6'h3b;
   localparam logic [5:0]  ADDR_STATUS  = 6'h3c;

   // word indices derived from the byte map
   localparam logic [4:0]  WIDX_OUT_LO  = ADDR_SUPPLY[5:1];
   localparam logic [4:0]  WIDX_OUT_HI  = ADDR_AUX[5:1];
   localparam logic [4:0]  WIDX_CFG_LO  = ADDR_CFG_LO[5:1];
   localparam logic [4:0]  WIDX_CFG_HI  = ADDR_CFG_HI[5:1];
   localparam logic [4:0]  WIDX_STATUS  = ADDR_STATUS[5:1];
   localparam int          OUT_N        = 11;
   localparam int          CFG_N        = 17;

   // outputs with 12 measurement bits: supply, temps, aux
   localparam logic [10:0] OUT_IS12     = 11'h781;

   // reset values
   localparam logic [15:0] RST_WORD     = 16'h0000;

   // link timing
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          LINK_PERIOD_NS = 125;
   localparam int          CS_GAP_NS      = 50;
   localparam int          HALF_CYC_I     =
      (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int          GAP_CYC_I      =
      (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  HALF_CYC       = 8'(HALF_CYC_I);
   localparam logic [7:0]  GAP_CYC        = 8'(GAP_CYC_I);

endpackage : isra_pkg

//--- logic/isra_if.sv
`timescale 1ns/1ps
interface isra_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_line;

   // data out floats high when the device lets go
   assign miso_line = miso_oe ? miso : 1'b1;

   modport dev  (input cs_n, input sclk, input mosi,
                 output miso, output miso_oe);
   modport host (output cs_n, output sclk, output mosi,
                 input miso_line);
endinterface : isra_if

//--- logic/isra_sync.sv
`timescale 1ns/1ps
module isra_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // level in and out
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   // two-flop synchroniser
   always_ff @(posedge clock) begin
      if (!resetn) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : isra_sync

//--- logic/isra_host.sv
`timescale 1ns/1ps
module isra_host
   import isra_pkg::*;
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   resetn,
   // link
   isra_if.host                        link,
   // command
   input  wire logic                   cmd_valid,
   output logic                        cmd_ready,
   input  wire logic                   cmd_write,
   input  wire logic [ADDR_W-1:0]      cmd_addr,
   input  wire logic [BYTE_W-1:0]      cmd_data,
   // response
   output logic                        rsp_valid,
   output logic [FRAME_BITS-1:0]       rsp_data
);
   typedef enum logic [2:0] {IDLE, SETUP, HIGH, LOW, HOLD, GAP} isra_hst_e;

   isra_hst_e             state_q;
   logic [7:0]            tmr_q;
   logic [3:0]            bit_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic                  sclk_q;
   logic                  cs_n_q;
   logic                  miso_s;

   // data in crosses from the device pin
   isra_sync u_sync (
      .clock  (clock),
      .resetn (resetn),
      .d      (link.miso_line),
      .q      (miso_s)
   );

   // pins from flops, mode 0, msb first
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = tx_q[FRAME_BITS-1];
   assign cmd_ready = (state_q == IDLE);

   // frame sequencer with clock divider
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q   <= IDLE;
         tmr_q     <= 8'h00;
         bit_q     <= 4'h0;
         tx_q      <= RST_WORD;
         rx_q      <= RST_WORD;
         sclk_q    <= 1'b0;
         cs_n_q    <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data  <= RST_WORD;
      end else begin
         rsp_valid <= 1'b0;
         if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
         end else begin
            case (state_q)
               IDLE: begin
                  if (cmd_valid) begin
                     // read frames carry the byte as filler
                     tx_q   <= {cmd_write, 1'b0, cmd_addr, cmd_data};
                     cs_n_q <= 1'b0;
                     bit_q  <= 4'h0;
                     tmr_q  <= HALF_CYC;
                     state_q <= SETUP;
                  end
               end
               SETUP, LOW: begin
                  sclk_q  <= 1'b1;
                  tmr_q   <= HALF_CYC;
                  state_q <= HIGH;
               end
               HIGH: begin
                  rx_q   <= {rx_q[FRAME_BITS-2:0], miso_s};
                  sclk_q <= 1'b0;
                  tmr_q  <= HALF_CYC;
                  if (bit_q == 4'hf) begin
                     state_q <= HOLD;
                  end else begin
                     bit_q   <= bit_q + 4'h1;
                     tx_q    <= {tx_q[FRAME_BITS-2:0], 1'b0};
                     state_q <= LOW;
                  end
               end
               HOLD: begin
                  cs_n_q    <= 1'b1;
                  rsp_valid <= 1'b1;
                  rsp_data  <= rx_q;
                  tmr_q     <= GAP_CYC;
                  state_q   <= GAP;
               end
               default: begin
                  state_q <= IDLE;
               end
            endcase
         end
      end
   end
endmodule : isra_host

//--- logic/isra_dev.sv
`timescale 1ns/1ps
// How it works
// - sixteen-bit registers, each byte separately addressed
// - chip select high floats output, ignores inputs
// - frame is chip select low, sixteen clocks
// - sixteen bits in and out per frame
// - write frame: 1, 0, address, data byte
// - one byte per write frame
// - write commits only after all sixteen clocks
// - read frame: 0, 0, then register address
// - last eight bits of read ignored
// - either byte address returns whole register
// - read data returned in the next frame
// - new flag, error flag, fourteen data bits
// - twelve-bit outputs leave bits 13, 12 zero
// - new flag cleared on read, set on sample
// - error flag tracks status error bits
// - rate outputs at 0x04 through 0x09
// - acceleration outputs at 0x0a through 0x0f
// - temperature outputs at 0x10 through 0x15
// - supply and aux outputs are unsigned twelve-bit
module isra_dev
   import isra_pkg::*;
(
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         resetn,
   // link
   isra_if.dev                               link,
   // sample feed
   input  wire logic                         sample_valid,
   input  wire logic [OUT_N-1:0][DATA_W-1:0] sample_data,
   input  wire logic [FRAME_BITS-1:0]        status_in,
   // configuration words
   output logic [CFG_N-1:0][FRAME_BITS-1:0]  cfg_words
);
   // ---------------- link clock domain ----------------
   logic [4:0]            rise_cnt_q;
   logic [3:0]            fall_cnt_q;
   logic [14:0]           shift_q;
   logic [FRAME_BITS-1:0] rx_word_q;
   logic                  frame_tgl_q;

   // ---------------- system clock domain --------------
   logic                  frame_tgl_s;
   logic                  frame_seen_q;
   logic                  frame_evt;
   logic                  cmd_wr;
   logic                  cmd_rd;
   logic [ADDR_W-1:0]     cmd_addr;
   logic [4:0]            widx;
   logic [3:0]            oidx;
   logic [4:0]            cidx;
   logic                  err_flag;
   logic [FRAME_BITS-1:0] rd_mux;
   logic [FRAME_BITS-1:0] rd_data_q;
   logic [FRAME_BITS-1:0] reply_q;
   logic                  cs_n_s;
   logic [DATA_W-1:0]     out_q [OUT_N];
   logic [OUT_N-1:0]      new_sample_flag_q;
   logic [FRAME_BITS-1:0] cfg_q [CFG_N];

   // word index belongs to an output data register
   function automatic logic is_out(input logic [4:0] w);
      is_out = (w >= WIDX_OUT_LO) && (w <= WIDX_OUT_HI);
   endfunction : is_out

   // word index belongs to a read/write configuration word
   function automatic logic is_cfg(input logic [4:0] w);
      is_cfg = (w >= WIDX_CFG_LO) && (w <= WIDX_CFG_HI);
   endfunction : is_cfg

   // bit counter, cleared by chip select between frames
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         rise_cnt_q <= 5'h00;
         shift_q    <= 15'h0000;
      end else begin
         if (rise_cnt_q != 5'(FRAME_BITS)) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
         end
         shift_q <= {shift_q[13:0], link.mosi};
      end
   end

   // whole frame captured on the sixteenth rising edge
   always_ff @(posedge link.sclk or negedge resetn) begin
      if (!resetn) begin
         rx_word_q   <= RST_WORD;
         frame_tgl_q <= 1'b0;
      end else if (!link.cs_n &&
                   rise_cnt_q == 5'(FRAME_BITS - 1)) begin
         rx_word_q   <= {shift_q, link.mosi};
         frame_tgl_q <= ~frame_tgl_q;
      end
   end

   // falling-edge bit pointer for data out
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         fall_cnt_q <= 4'h0;
      end else if (fall_cnt_q != 4'hf) begin
         fall_cnt_q <= fall_cnt_q + 4'h1;
      end
   end

   // data out launched msb first, driven only inside a frame
   assign link.miso    = rd_data_q[4'hf - fall_cnt_q];
   assign link.miso_oe = ~link.cs_n;

   // frame-done toggle into the system clock
   isra_sync u_sync (
      .clock  (clock),
      .resetn (resetn),
      .d      (frame_tgl_q),
      .q      (frame_tgl_s)
   );

   // chip select level into the system clock
   isra_sync u_sel_sync (
      .clock  (clock),
      .resetn (resetn),
      .d      (link.cs_n),
      .q      (cs_n_s)
   );

   // toggle edge marks one complete frame
   always_ff @(posedge clock) begin
      if (!resetn) begin
         frame_seen_q <= 1'b0;
      end else begin
         frame_seen_q <= frame_tgl_s;
      end
   end

   // frame decode; rx word is stable long after the toggle
   assign frame_evt = frame_tgl_s ^ frame_seen_q;
   assign cmd_wr    = frame_evt && rx_word_q[BIT_WRITE]
                      && !rx_word_q[BIT_ZERO];
   assign cmd_rd    = frame_evt && !rx_word_q[BIT_WRITE]
                      && !rx_word_q[BIT_ZERO];
   assign cmd_addr  = rx_word_q[ADDR_MSB:ADDR_LSB];
   assign widx      = cmd_addr[5:1];
   assign oidx      = 4'(widx - WIDX_OUT_LO);
   assign cidx      = 5'(widx - WIDX_CFG_LO);
   assign err_flag  = |status_in;

   // read multiplexer over the register map
   always_comb begin
      rd_mux = RST_WORD;
      if (is_out(widx)) begin
         rd_mux = {new_sample_flag_q[oidx], err_flag, out_q[oidx]};
      end else if (is_cfg(widx)) begin
         rd_mux = cfg_q[cidx];
      end else if (widx == WIDX_STATUS) begin
         rd_mux = status_in;
      end
   end

   // reply word for the next frame; other frames answer zero
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reply_q <= RST_WORD;
      end else if (frame_evt) begin
         reply_q <= cmd_rd ? rd_mux : RST_WORD;
      end
   end

   // data out word moves only while deselected, never mid-bit
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_data_q <= RST_WORD;
      end else if (cs_n_s) begin
         rd_data_q <= reply_q;
      end
   end

   // output data registers and their new-data flags
   generate
      for (genvar i = 0; i < OUT_N; i++) begin : g_out
         localparam logic [13:0] MASK = OUT_IS12[i] ? MASK_12 : MASK_14;

         // sample load, twelve-bit outputs masked
         always_ff @(posedge clock) begin
            if (!resetn) begin
               out_q[i] <= 14'h0000;
            end else if (sample_valid) begin
               out_q[i] <= sample_data[i] & MASK;
            end
         end

         // new sample wins over a read in the same cycle
         always_ff @(posedge clock) begin
            if (!resetn) begin
               new_sample_flag_q[i] <= 1'b0;
            end else if (sample_valid) begin
               new_sample_flag_q[i] <= 1'b1;
            end else if (cmd_rd && is_out(widx) &&
                         oidx == 4'(i)) begin
               new_sample_flag_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // configuration words, one byte per write frame
   generate
      for (genvar j = 0; j < CFG_N; j++) begin : g_cfg
         always_ff @(posedge clock) begin
            if (!resetn) begin
               cfg_q[j] <= RST_WORD;
            end else if (cmd_wr && is_cfg(widx) &&
                         cidx == 5'(j)) begin
               if (cmd_addr[0]) begin
                  cfg_q[j][15:8] <= rx_word_q[7:0];
               end else begin
                  cfg_q[j][7:0]  <= rx_word_q[7:0];
               end
            end
         end
         assign cfg_words[j] = cfg_q[j];
      end
   endgenerate

endmodule : isra_dev

//--- verif/isra_monitor.sv
`timescale 1ns/1ps
module isra_monitor (
   // system clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // link wires
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic miso,
   input  wire logic miso_oe,
   input  wire logic miso_line
);
   logic       sclk_q;
   logic [4:0] rise_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   // count link clock rises inside a frame
   always_ff @(posedge clock) begin
      sclk_q <= sclk;
      if (!resetn || cs_n) rise_q <= 5'h00;
      else if (sclk && !sclk_q) rise_q <= rise_q + 5'h01;
   end

   property p_float; cs_n |-> !miso_oe && miso_line; endproperty
   a_float: assert property (p_float)
      else $error("data out driven while deselected");
   property p_drive; !cs_n |-> miso_oe && miso_line == miso; endproperty
   a_drive: assert property (p_drive)
      else $error("data out not driven in frame");
   property p_idle; cs_n |-> !sclk; endproperty
   a_idle: assert property (p_idle)
      else $error("link clock moves outside frame");
   property p_count; $rose(cs_n) |-> rise_q == 5'h10; endproperty
   a_count: assert property (p_count)
      else $error("frame without sixteen clocks");
   property p_extra; !cs_n |-> rise_q <= 5'h10; endproperty
   a_extra: assert property (p_extra)
      else $error("more than sixteen clocks");
   property p_setup; $fell(cs_n) |-> !sclk [*8]; endproperty
   a_setup: assert property (p_setup)
      else $error("clock rises too soon after select");
   property p_miso; !cs_n && sclk && sclk_q |-> $stable(miso); endproperty
   a_miso: assert property (p_miso)
      else $error("data out moved while clock high");
   property p_mosi; !cs_n && sclk && sclk_q |-> $stable(mosi); endproperty
   a_mosi: assert property (p_mosi)
      else $error("data in moved while clock high");
   property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
   a_gap: assert property (p_gap)
      else $error("select gap too short");
   property p_len; $fell(cs_n) |-> ##[400:480] $rose(cs_n); endproperty
   a_len: assert property (p_len)
      else $error("frame length out of range");
endmodule : isra_monitor

//--- verif/imu_spi_register_access_tb.sv
`timescale 1ns/1ps
module imu_spi_register_access_tb
   import isra_pkg::*;
;
   logic                         clock, resetn, sample_valid;
   logic                         cmd_valid, cmd_ready, cmd_write;
   logic [ADDR_W-1:0]            cmd_addr;
   logic [BYTE_W-1:0]            cmd_data;
   logic                         rsp_valid;
   logic [15:0]                  rsp_data, status_in, pend;
   logic [OUT_N-1:0][DATA_W-1:0] sample_data;
   logic [CFG_N-1:0][15:0]       cfg_words, cfg_m;
   logic [OUT_N-1:0]             new_m;
   logic [31:0]                  seed;
   logic [15:0]                  exp_q[$];
   int                           errors, tests_run;

   isra_if isra_if_i ();
   isra_host isra_host_i (.clock(clock), .resetn(resetn),
      .link(isra_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   isra_dev isra_dev_i (.clock(clock), .resetn(resetn),
      .link(isra_if_i), .sample_valid(sample_valid),
      .sample_data(sample_data), .status_in(status_in),
      .cfg_words(cfg_words));
   isra_monitor isra_monitor_i (.clock(clock), .resetn(resetn),
      .cs_n(isra_if_i.cs_n), .sclk(isra_if_i.sclk),
      .mosi(isra_if_i.mosi), .miso(isra_if_i.miso),
      .miso_oe(isra_if_i.miso_oe), .miso_line(isra_if_i.miso_line));

   // system clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   // wait for the host to be idle, bounded
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clock);
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      if (cmd_ready !== 1'b1) begin
         errors++;
      end
   endtask : wait_idle

   // one frame; notes the reply due in the following frame
   task automatic xfer(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
      logic [15:0] nxt;
      logic [4:0]  w;
      w = a[5:1];
      nxt = 16'h0000;
      if (wr && w >= WIDX_CFG_LO && w <= WIDX_CFG_HI) begin
         if (a[0]) cfg_m[w-WIDX_CFG_LO][15:8] = d;
         else cfg_m[w-WIDX_CFG_LO][7:0] = d;
      end else if (!wr && w >= WIDX_OUT_LO && w <= WIDX_OUT_HI) begin
         nxt = {new_m[w-WIDX_OUT_LO], |status_in, sample_data[w-WIDX_OUT_LO]
            & (OUT_IS12[w-WIDX_OUT_LO] ? MASK_12 : MASK_14)};
         new_m[w-WIDX_OUT_LO] = 1'b0;
      end else if (!wr && w >= WIDX_CFG_LO && w <= WIDX_CFG_HI)
         nxt = cfg_m[w-WIDX_CFG_LO];
      else if (!wr && w == WIDX_STATUS)
         nxt = status_in;
      exp_q.push_back(pend);
      pend = nxt;
      wait_idle();
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clock);
      cmd_valid = 1'b0;
   endtask : xfer

   // fresh random sample into all outputs
   task automatic new_sample();
      wait_idle();
      for (int i = 0; i < OUT_N; i++) begin
         seed = lfsr(seed);
         sample_data[i] = seed[13:0];
      end
      sample_valid = 1'b1;
      new_m = '1;
      @(negedge clock);
      sample_valid = 1'b0;
   endtask : new_sample

   // compare each reply with the oldest note
   always @(negedge clock) begin
      if (rsp_valid === 1'b1)
         check(rsp_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
   end

   // main sequence
   initial begin
      {resetn, cmd_valid, cmd_write, cmd_addr, cmd_data} = '0;
      {sample_valid, sample_data, status_in, pend, new_m, cfg_m} = '0;
      {errors, tests_run} = '0;
      seed = 32'h213c89ee;
      repeat (20) @(negedge clock);
      resetn = 1'b1;
      new_sample();
      for (int p = 0; p < 3; p++) begin
         wait_idle();
         if (p == 1) status_in = 16'h0001 << seed[3:0];
         if (p == 2) begin
            new_sample();
            xfer(1'b1, ADDR_RATE_X, 8'h55);
         end
         for (int i = 0; i < OUT_N; i++) begin
            seed = lfsr(seed);
            xfer(1'b0, 6'(ADDR_SUPPLY + 2 * i + (i + p) % 2),
                 seed[7:0]);
         end
      end
      $display("test done: output registers");
      for (int k = 0; k < 4; k++) begin
         int j;
         j = k * 16 / 3;
         seed = lfsr(seed);
         xfer(1'b1, ADDR_CFG_LO + 6'(2 * j), seed[7:0]);
         xfer(1'b1, ADDR_CFG_LO + 6'(2 * j + 1), seed[15:8]);
         xfer(1'b0, ADDR_CFG_LO + 6'(2 * j + k % 2), seed[23:16]);
         wait_idle();
         check(cfg_words[j], cfg_m[j]);
      end
      xfer(1'b0, ADDR_STATUS, seed[7:0]);
      xfer(1'b1, 6'h00, 8'ha5);
      for (int n = 0; n < 1000 && exp_q.size() > 0; n++) @(negedge clock);
      check(16'(exp_q.size()), 16'h0000);
      $display("test done: configuration words");
      final_report();
   end

   // hang guard
   initial begin
      repeat (80000) @(posedge clock);
      errors++;
      final_report();
   end
endmodule : imu_spi_register_access_tb
